// ### logic/hcos_map.vh
// hcos_map.vh - constants of the hub configuration option select block
`ifndef HCOS_MAP_VH
`define HCOS_MAP_VH

// register byte offsets
`define HCOS_REG_VEND 5'h00
`define HCOS_REG_PROD 5'h04
`define HCOS_REG_REL 5'h08
`define HCOS_REG_OPT 5'h0C
`define HCOS_REG_CTRL 5'h10
`define HCOS_REG_STAT 5'h14

// option word fields
`define HCOS_OPT_SELF 0
`define HCOS_OPT_IND 1
`define HCOS_OPT_HSDIS 2
`define HCOS_OPT_MTT 3
`define HCOS_OPT_EOP 4
`define HCOS_OPT_SNS_LO 5
`define HCOS_OPT_SNS_HI 6
`define HCOS_OPT_GANG 7
`define HCOS_OPT_CMPD 8
`define HCOS_OPT_NREM_LO 9
`define HCOS_OPT_NREM_HI 12

// current sensing modes
`define HCOS_SNS_PORT 2'h0
`define HCOS_SNS_GANG 2'h1
`define HCOS_SNS_NONE 2'h2

// source select codes {hi,mid,lo}
`define HCOS_SRC_DEFAULT 3'h0
`define HCOS_SRC_EEPROM 3'h1
`define HCOS_SRC_MGMT 3'h2

// control bit: apply management image
`define HCOS_CTRL_APPLY 0

// eeprom byte positions
`define HCOS_EE_OPT_LO 3'h6
`define HCOS_EE_OPT_HI 3'h7

// reset values and sizes
`define HCOS_RST_WORD 16'h0000
`define HCOS_NP_BUFS 4'h4
`define HCOS_STRAP_W 10

`endif

// ### logic/hcos_strap_latch.v
// hcos_strap_latch.v - captures strap levels once after reset release
`timescale 1ns/100ps
module hcos_strap_latch #(
	parameter WIDTH = 8
) (
	clk,
	reset_n,
	strap_in,
	strap_q,
	taken_q
);
	input wire clk;
	input wire reset_n;
	input wire [WIDTH-1:0] strap_in;
	output reg [WIDTH-1:0] strap_q;
	output reg taken_q;

	// first edge after release takes the pins, then holds
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_q <= {WIDTH{1'b0}};
			taken_q <= 1'b0;
		end else if (!taken_q) begin
			strap_q <= strap_in;
			taken_q <= 1'b1;
		end
	end
endmodule // hcos_strap_latch

// ### logic/hcos_top.v
// hcos_top.v - hub configuration source select and option apply
//
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "hcos_map.vh"
module hcos_top #(
	parameter [15:0] DEF_VENDOR = 16'hA5A5, // arbitrary value
	parameter [15:0] DEF_PRODUCT = 16'h3C3C, // arbitrary value
	parameter [15:0] DEF_RELEASE = 16'h0000,
	parameter [2:0] PORTS = 3'h4
) (
	clk,
	reset_n,
	config_source_strap_hi,
	config_source_strap_mid,
	config_source_strap_lo,
	local_supply_detect,
	port_indicator_strap,
	multi_translator_strap,
	grouped_power_strap,
	non_removable_strap,
	host_force_single_tt,
	link_full_speed,
	ee_byte_valid,
	ee_byte_index,
	ee_byte_data,
	ee_load_done,
	avs_address,
	avs_read,
	avs_write,
	avs_writedata,
	avs_byteenable,
	avs_readdata,
	avs_waitrequest,
	config_valid,
	vendor_identifier,
	product_identifier,
	release_number,
	self_powered,
	port_indicators_en,
	full_speed_only,
	multi_tt,
	translator_count,
	np_buffers_per_tt,
	eop_at_eof1_en,
	current_sense_mode,
	ganged_power,
	compound_device,
	non_removable_ports
);
	input wire clk;
	input wire reset_n;
	input wire config_source_strap_hi;
	input wire config_source_strap_mid;
	input wire config_source_strap_lo;
	input wire local_supply_detect;
	input wire port_indicator_strap;
	input wire multi_translator_strap;
	input wire grouped_power_strap;
	input wire [1:0] non_removable_strap;
	input wire host_force_single_tt;
	input wire link_full_speed;
	input wire ee_byte_valid;
	input wire [2:0] ee_byte_index;
	input wire [7:0] ee_byte_data;
	input wire ee_load_done;
	input wire [4:0] avs_address;
	input wire avs_read;
	input wire avs_write;
	input wire [31:0] avs_writedata;
	input wire [3:0] avs_byteenable;
	output reg [31:0] avs_readdata;
	output reg avs_waitrequest;
	output reg config_valid;
	output reg [15:0] vendor_identifier;
	output reg [15:0] product_identifier;
	output reg [15:0] release_number;
	output reg self_powered;
	output reg port_indicators_en;
	output reg full_speed_only;
	output reg multi_tt;
	output reg [2:0] translator_count;
	output reg [3:0] np_buffers_per_tt;
	output reg eop_at_eof1_en;
	output reg [1:0] current_sense_mode;
	output reg ganged_power;
	output reg compound_device;
	output reg [3:0] non_removable_ports;

	// one-hot loader states
	localparam [2:0] ST_CAPTURE = 3'h1;
	localparam [2:0] ST_LOAD = 3'h2;
	localparam [2:0] ST_DONE = 3'h4;

	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [15:0] img_vend_q;
	reg [15:0] img_prod_q;
	reg [15:0] img_rel_q;
	reg [15:0] img_opt_q;
	reg apply_q;
	wire [`HCOS_STRAP_W-1:0] strap_pins;
	wire [`HCOS_STRAP_W-1:0] strap_q;
	wire strap_taken;
	wire [2:0] src_sel;
	wire use_default;
	wire use_eeprom;
	wire use_mgmt;
	wire s_self;
	wire [1:0] s_nrem;
	reg [15:0] eff_vend;
	reg [15:0] eff_prod;
	reg [15:0] eff_rel;
	reg [15:0] eff_opt;
	reg [1:0] eff_sns;
	wire load_complete;
	wire bus_req;
	wire bus_ack;
	wire wr_ok;
	reg [31:0] rd_d;

	assign strap_pins = {config_source_strap_hi, config_source_strap_mid,
		config_source_strap_lo, local_supply_detect, port_indicator_strap,
		multi_translator_strap, grouped_power_strap, non_removable_strap,
		1'b0};

	// straps sampled once after reset release
	hcos_strap_latch #(
		.WIDTH(`HCOS_STRAP_W)
	) u_strap (
		.clk(clk),
		.reset_n(reset_n),
		.strap_in(strap_pins),
		.strap_q(strap_q),
		.taken_q(strap_taken)
	);

	// source decode; unknown codes fall back to defaults
	assign src_sel = strap_q[9:7];
	assign use_eeprom = (src_sel == `HCOS_SRC_EEPROM);
	assign use_mgmt = (src_sel == `HCOS_SRC_MGMT);
	assign use_default = !use_eeprom && !use_mgmt;
	assign s_self = strap_q[6]; // high means local power
	assign s_nrem = strap_q[2:1];

	// image complete for the selected source
	assign load_complete = use_default || (use_eeprom && ee_load_done) ||
		(use_mgmt && apply_q);

	// loader sequence: capture straps, wait image, hold
	always @* begin
		case (state_q)
			ST_CAPTURE: state_d = strap_taken ? ST_LOAD : ST_CAPTURE;
			ST_LOAD: state_d = load_complete ? ST_DONE : ST_LOAD;
			ST_DONE: state_d = ST_DONE;
			default: state_d = ST_CAPTURE;
		endcase
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_CAPTURE;
		end else begin
			state_q <= state_d;
		end
	end

	// bus handshake: one wait cycle, then one ready cycle
	assign bus_req = avs_read || avs_write;
	assign bus_ack = bus_req && !avs_waitrequest;
	assign wr_ok = avs_write && bus_ack && use_mgmt &&
		(state_q == ST_LOAD);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !(bus_req && avs_waitrequest);
		end
	end

	// image words: management writes or eeprom bytes
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			img_vend_q <= `HCOS_RST_WORD;
			img_prod_q <= `HCOS_RST_WORD;
			img_rel_q <= `HCOS_RST_WORD;
			img_opt_q <= `HCOS_RST_WORD;
			apply_q <= 1'b0;
		end else if (wr_ok) begin
			if (avs_address == `HCOS_REG_VEND) begin
				if (avs_byteenable[0]) img_vend_q[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1]) img_vend_q[15:8] <= avs_writedata[15:8];
			end
			if (avs_address == `HCOS_REG_PROD) begin
				if (avs_byteenable[0]) img_prod_q[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1]) img_prod_q[15:8] <= avs_writedata[15:8];
			end
			if (avs_address == `HCOS_REG_REL) begin
				if (avs_byteenable[0]) img_rel_q[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1]) img_rel_q[15:8] <= avs_writedata[15:8];
			end
			if (avs_address == `HCOS_REG_OPT) begin
				if (avs_byteenable[0]) img_opt_q[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1]) img_opt_q[15:8] <= avs_writedata[15:8];
			end
			if (avs_address == `HCOS_REG_CTRL && avs_byteenable[0]) begin
				apply_q <= avs_writedata[`HCOS_CTRL_APPLY];
			end
		end else if (ee_byte_valid && use_eeprom && state_q == ST_LOAD) begin
			case (ee_byte_index)
				3'h0: img_vend_q[7:0] <= ee_byte_data;
				3'h1: img_vend_q[15:8] <= ee_byte_data;
				3'h2: img_prod_q[7:0] <= ee_byte_data;
				3'h3: img_prod_q[15:8] <= ee_byte_data;
				3'h4: img_rel_q[7:0] <= ee_byte_data;
				3'h5: img_rel_q[15:8] <= ee_byte_data;
				`HCOS_EE_OPT_LO: img_opt_q[7:0] <= ee_byte_data;
				`HCOS_EE_OPT_HI: img_opt_q[15:8] <= ee_byte_data;
				default: img_opt_q <= img_opt_q;
			endcase
		end
	end

	// effective configuration from the chosen source
	always @* begin
		eff_opt = img_opt_q;
		eff_vend = img_vend_q;
		eff_prod = img_prod_q;
		eff_rel = img_rel_q;
		if (use_default) begin
			eff_vend = DEF_VENDOR;
			eff_prod = DEF_PRODUCT;
			eff_rel = DEF_RELEASE;
			eff_opt = 16'h0000;
			eff_opt[`HCOS_OPT_SELF] = s_self;
			eff_opt[`HCOS_OPT_IND] = strap_q[5];
			eff_opt[`HCOS_OPT_MTT] = strap_q[4];
			eff_opt[`HCOS_OPT_GANG] = strap_q[3];
			// ganged when self-powered, none when bus-powered
			eff_opt[`HCOS_OPT_SNS_HI:`HCOS_OPT_SNS_LO] = s_self ?
				`HCOS_SNS_GANG : `HCOS_SNS_NONE;
			eff_opt[`HCOS_OPT_NREM_LO+1:`HCOS_OPT_NREM_LO] = s_nrem;
			eff_opt[`HCOS_OPT_CMPD] = |s_nrem;
		end
		// no sensing is refused while self-powered
		eff_sns = eff_opt[`HCOS_OPT_SNS_HI:`HCOS_OPT_SNS_LO];
		if (eff_sns != `HCOS_SNS_PORT && eff_sns != `HCOS_SNS_GANG &&
			eff_opt[`HCOS_OPT_SELF]) begin
			eff_sns = `HCOS_SNS_GANG;
		end else if (eff_sns != `HCOS_SNS_PORT &&
			eff_sns != `HCOS_SNS_GANG) begin
			eff_sns = `HCOS_SNS_NONE;
		end
	end

	// configuration outputs, set once the image is complete
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			config_valid <= 1'b0;
			vendor_identifier <= `HCOS_RST_WORD;
			product_identifier <= `HCOS_RST_WORD;
			release_number <= `HCOS_RST_WORD;
			self_powered <= 1'b0;
			port_indicators_en <= 1'b0;
			full_speed_only <= 1'b0;
			current_sense_mode <= `HCOS_SNS_NONE;
			ganged_power <= 1'b0;
			compound_device <= 1'b0;
			non_removable_ports <= 4'h0;
		end else if (state_q == ST_LOAD && load_complete) begin
			config_valid <= 1'b1;
			vendor_identifier <= eff_vend;
			product_identifier <= eff_prod;
			release_number <= eff_rel;
			self_powered <= eff_opt[`HCOS_OPT_SELF];
			port_indicators_en <= eff_opt[`HCOS_OPT_IND];
			full_speed_only <= eff_opt[`HCOS_OPT_HSDIS];
			current_sense_mode <= eff_sns;
			ganged_power <= eff_opt[`HCOS_OPT_GANG];
			compound_device <= eff_opt[`HCOS_OPT_CMPD];
			non_removable_ports <=
				eff_opt[`HCOS_OPT_NREM_HI:`HCOS_OPT_NREM_LO];
		end
	end

	// translator mode; host may force single at any time
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			multi_tt <= 1'b0;
			translator_count <= 3'h0;
			np_buffers_per_tt <= 4'h0;
			eop_at_eof1_en <= 1'b0;
		end else if (config_valid) begin
			multi_tt <= img_opt_eff_mtt(use_default, strap_q[4],
				img_opt_q[`HCOS_OPT_MTT]) && !host_force_single_tt;
			translator_count <= (img_opt_eff_mtt(use_default, strap_q[4],
				img_opt_q[`HCOS_OPT_MTT]) && !host_force_single_tt) ?
				PORTS : 3'h1;
			np_buffers_per_tt <= `HCOS_NP_BUFS;
			// early EOP only on a full-speed link
			eop_at_eof1_en <= !use_default && img_opt_q[`HCOS_OPT_EOP] &&
				(full_speed_only || link_full_speed);
		end
	end

	// multi-translator choice by source
	function img_opt_eff_mtt;
		input dflt;
		input strap_bit;
		input img_bit;
		begin
			img_opt_eff_mtt = dflt ? strap_bit : img_bit;
		end
	endfunction

	// register read mux
	always @* begin
		rd_d = 32'h00000000;
		case (avs_address)
			`HCOS_REG_VEND: rd_d[15:0] = use_mgmt ? img_vend_q : vendor_identifier;
			`HCOS_REG_PROD: rd_d[15:0] = use_mgmt ? img_prod_q : product_identifier;
			`HCOS_REG_REL: rd_d[15:0] = use_mgmt ? img_rel_q : release_number;
			`HCOS_REG_OPT: rd_d[15:0] = img_opt_q;
			`HCOS_REG_CTRL: rd_d[`HCOS_CTRL_APPLY] = apply_q;
			`HCOS_REG_STAT: rd_d = {16'h0000, config_valid, src_sel,
				non_removable_ports, compound_device, ganged_power,
				current_sense_mode, multi_tt, full_speed_only,
				port_indicators_en, self_powered};
			default: rd_d = 32'h00000000;
		endcase
	end

	// read data loaded as waitrequest falls
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= rd_d;
		end
	end
endmodule // hcos_top

// ### tb/hcos_checker_assertions.sv
// concurrent checks on the ports of hcos_top
`timescale 1ns/100ps
`include "hcos_map.vh"
module hcos_checker (
	input wire clk,
	input wire reset_n,
	input wire config_source_strap_hi,
	input wire config_source_strap_mid,
	input wire config_source_strap_lo,
	input wire host_force_single_tt,
	input wire link_full_speed,
	input wire avs_read,
	input wire avs_write,
	input wire avs_waitrequest,
	input wire config_valid,
	input wire [15:0] vendor_identifier,
	input wire self_powered,
	input wire full_speed_only,
	input wire multi_tt,
	input wire [2:0] translator_count,
	input wire [3:0] np_buffers_per_tt,
	input wire eop_at_eof1_en,
	input wire [1:0] current_sense_mode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// release with straps picking built-in defaults
	sequence s_dflt_go;
		$rose(reset_n) && {config_source_strap_hi, config_source_strap_mid,
			config_source_strap_lo} == `HCOS_SRC_DEFAULT;
	endsequence
	sequence s_valid_soon;
		##[1:4] config_valid;
	endsequence
	// bus request waiting, then one low cycle of waitrequest
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ack;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	a_default_soon: assert property (s_dflt_go |-> s_valid_soon)
		else $error("defaults not applied after release");
	a_bus_ack: assert property (s_req |=> s_ack)
		else $error("waitrequest answer not one cycle");
	a_valid_held: assert property (config_valid |=> config_valid)
		else $error("config valid dropped");
	a_ids_stable: assert property (
		config_valid && $past(config_valid) |->
		$stable(vendor_identifier) && $stable(self_powered))
		else $error("applied config changed");
	// translator fields follow config_valid by one cycle
	a_tt_count: assert property (
		config_valid && $past(config_valid) |->
		translator_count == (multi_tt ? 3'h4 : 3'h1))
		else $error("translator count wrong");
	a_np_bufs: assert property (config_valid && multi_tt |->
		np_buffers_per_tt == `HCOS_NP_BUFS)
		else $error("buffers per translator wrong");
	a_host_single: assert property (
		config_valid && host_force_single_tt |=> !multi_tt)
		else $error("host single translator ignored");
	a_sense_self: assert property (config_valid && self_powered |->
		current_sense_mode != `HCOS_SNS_NONE)
		else $error("no sensing while self powered");
	a_eop_fs: assert property (eop_at_eof1_en |->
		$past(link_full_speed) || full_speed_only)
		else $error("early eop outside full speed");
endmodule // hcos_checker
bind hcos_top hcos_checker u_chk (.clk, .reset_n, .config_source_strap_hi,
	.config_source_strap_mid, .config_source_strap_lo, .host_force_single_tt,
	.link_full_speed, .avs_read, .avs_write, .avs_waitrequest, .config_valid,
	.vendor_identifier, .self_powered, .full_speed_only, .multi_tt,
	.translator_count, .np_buffers_per_tt, .eop_at_eof1_en,
	.current_sense_mode);

// ### tb/hcos_host_model.sv
// upstream host model driving its live hints to the hub
`timescale 1ns/100ps
module hcos_host_model (
	input wire clk,
	input wire reset_n,
	input wire want_single,
	input wire want_fs,
	output reg host_force_single_tt,
	output reg link_full_speed
);
	// hints change only just after a rising edge
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			host_force_single_tt <= 1'b0;
			link_full_speed <= 1'b0;
		end else begin
			host_force_single_tt <= want_single;
			link_full_speed <= want_fs;
		end
	end
endmodule // hcos_host_model

// ### tb/hub_config_option_select_bench.sv
// self-checking bench of hcos_top
`timescale 1ns/100ps
`include "hcos_map.vh"
module hub_config_option_select_bench;
	localparam [15:0] VEND = 16'h5A5A; // arbitrary value
	localparam [15:0] PROD = 16'hC3C3; // arbitrary value
	reg clk = 1'b0;
	reg reset_n, config_source_strap_hi, config_source_strap_mid;
	reg config_source_strap_lo, local_supply_detect, port_indicator_strap;
	reg multi_translator_strap, grouped_power_strap, ee_byte_valid;
	reg ee_load_done, avs_read, avs_write, want_single, want_fs;
	reg [1:0] non_removable_strap;
	reg [2:0] ee_byte_index;
	reg [7:0] ee_byte_data;
	reg [4:0] avs_address;
	reg [3:0] avs_byteenable;
	reg [31:0] avs_writedata, rd;
	wire host_force_single_tt, link_full_speed, avs_waitrequest, config_valid;
	wire self_powered, port_indicators_en, full_speed_only, multi_tt;
	wire eop_at_eof1_en, ganged_power, compound_device;
	wire [31:0] avs_readdata;
	wire [15:0] vendor_identifier, product_identifier, release_number;
	wire [2:0] translator_count;
	wire [3:0] np_buffers_per_tt, non_removable_ports;
	wire [1:0] current_sense_mode;
	integer num_errors = 0, samples_checked = 0;
	// 50 MHz clock
	always #10 clk = ~clk;
	hcos_top #(.DEF_VENDOR(VEND), .DEF_PRODUCT(PROD)) dut (.clk, .reset_n,
		.config_source_strap_hi, .config_source_strap_mid,
		.config_source_strap_lo, .local_supply_detect, .port_indicator_strap,
		.multi_translator_strap, .grouped_power_strap, .non_removable_strap,
		.host_force_single_tt, .link_full_speed, .ee_byte_valid, .ee_byte_index,
		.ee_byte_data, .ee_load_done, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.config_valid, .vendor_identifier, .product_identifier, .release_number,
		.self_powered, .port_indicators_en, .full_speed_only, .multi_tt,
		.translator_count, .np_buffers_per_tt, .eop_at_eof1_en,
		.current_sense_mode, .ganged_power, .compound_device,
		.non_removable_ports);
	hcos_host_model host (.clk, .reset_n, .want_single, .want_fs,
		.host_force_single_tt, .link_full_speed);
	// compare and count
	task check(input [31:0] seen, input [31:0] exp, input [63:0] what);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				num_errors = num_errors + 1;
				$display("mismatch %0s exp %h seen %h", what, exp, seen);
			end
		end
	endtask
	// straps {src, supply, ind, mtt, gang, nrem} held through reset
	task boot(input [8:0] s);
		begin
			reset_n <= 1'b0;
			{config_source_strap_hi, config_source_strap_mid,
				config_source_strap_lo, local_supply_detect, port_indicator_strap,
				multi_translator_strap, grouped_power_strap,
				non_removable_strap} <= s;
			repeat (2) @(posedge clk);
			reset_n <= 1'b1;
			repeat (5) @(posedge clk);
		end
	endtask
	// one avalon cycle, held until waitrequest is sampled low
	// no local limit: only the watchdog ends a hung wait
	task bus(input wr, input [4:0] a, input [31:0] d);
		begin
			avs_address <= a;
			avs_writedata <= d;
			avs_write <= wr;
			avs_read <= !wr;
			@(posedge clk);
			while (avs_waitrequest !== 1'b0) begin
				@(posedge clk);
			end
			rd = avs_readdata;
			avs_write <= 1'b0;
			avs_read <= 1'b0;
			@(posedge clk);
		end
	endtask
	// eight bytes back to back, then done
	task ee_load(input [63:0] img);
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				ee_byte_valid <= 1'b1;
				ee_byte_index <= i[2:0];
				ee_byte_data <= img[8*i +: 8];
				@(posedge clk);
			end
			ee_byte_valid <= 1'b0;
			ee_load_done <= 1'b1;
			@(posedge clk);
			ee_load_done <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask
	task t_dflt_self;
		begin
			boot({`HCOS_SRC_DEFAULT, 1'b1, 1'b1, 1'b1, 1'b0, 2'h2});
			check(config_valid, 1, "valid");
			check(vendor_identifier, VEND, "vendor");
			check(product_identifier, PROD, "product");
			check(release_number, 16'h0000, "release");
			check(self_powered, 1, "self");
			check(port_indicators_en, 1, "ind");
			check(translator_count, 3'h4, "tts");
			check(current_sense_mode, `HCOS_SNS_GANG, "sense");
			check(ganged_power, 0, "gang");
			check(compound_device, 1, "cmpd");
			{port_indicator_strap, local_supply_detect} <= 2'h0;
			want_single <= 1'b1;
			repeat (3) @(posedge clk);
			check(port_indicators_en, 1, "held");
			check(multi_tt, 0, "forced");
			want_single <= 1'b0;
			$display("test default self done");
		end
	endtask
	task t_dflt_bus;
		begin
			// unassigned source code falls back to defaults
			boot({3'h7, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0});
			check(config_valid, 1, "valid");
			check(vendor_identifier, VEND, "vendor");
			check(self_powered, 0, "self");
			check(current_sense_mode, `HCOS_SNS_NONE, "sense");
			check(translator_count, 3'h1, "tts");
			check(ganged_power, 1, "gang");
			check(compound_device, 0, "cmpd");
			$display("test default bus done");
		end
	endtask
	task t_ee;
		begin
			boot({`HCOS_SRC_EEPROM, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0});
			check(config_valid, 0, "early");
			ee_load(64'h0397010956781234);
			check(vendor_identifier, 16'h1234, "vendor");
			check(product_identifier, 16'h5678, "product");
			check(release_number, 16'h0109, "release");
			check(port_indicators_en, 1, "ind");
			check(full_speed_only, 1, "fsonly");
			check(multi_tt, 0, "mtt");
			check(eop_at_eof1_en, 1, "eop");
			check(current_sense_mode, `HCOS_SNS_PORT, "sense");
			check(non_removable_ports, 4'h1, "nrem");
			ee_byte_valid <= 1'b1;
			ee_byte_index <= 3'h0;
			ee_byte_data <= 8'hFF;
			@(posedge clk);
			ee_byte_valid <= 1'b0;
			repeat (2) @(posedge clk);
			check(vendor_identifier, 16'h1234, "late");
			$display("test eeprom done");
		end
	endtask
	task t_mgmt;
		begin
			boot({`HCOS_SRC_MGMT, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0});
			bus(1'b1, `HCOS_REG_VEND, 32'h0000ABCD);
			bus(1'b1, `HCOS_REG_PROD, 32'h00000102);
			bus(1'b1, `HCOS_REG_REL, 32'h00000200);
			bus(1'b1, `HCOS_REG_OPT, 32'h00000059);
			bus(1'b0, 5'h1C, 32'h0);
			check(rd, 32'h0, "unmapped");
			bus(1'b1, `HCOS_REG_CTRL, 32'h00000001);
			repeat (2) @(posedge clk);
			check(vendor_identifier, 16'hABCD, "vendor");
			check(product_identifier, 16'h0102, "product");
			check(release_number, 16'h0200, "release");
			check(current_sense_mode, `HCOS_SNS_GANG, "sense");
			check(eop_at_eof1_en, 0, "eop hs");
			want_fs <= 1'b1;
			repeat (3) @(posedge clk);
			check(eop_at_eof1_en, 1, "eop fs");
			bus(1'b1, `HCOS_REG_VEND, 32'h00001111);
			check(vendor_identifier, 16'hABCD, "late");
			bus(1'b0, `HCOS_REG_STAT, 32'h0);
			check(rd, 32'h0000A019, "stat");
			want_fs <= 1'b0;
			$display("test management done");
		end
	endtask
	// counts, verdict and stop
	task end_sim;
		begin
			$display("checks %0d mismatches %0d", samples_checked, num_errors);
			if (num_errors == 0 && samples_checked > 0) begin
				$display("TB: PASS");
			end else begin
				$display("TB: FAIL");
			end
			$finish;
		end
	endtask
	// main sequence
	initial begin
		{ee_byte_valid, ee_load_done, avs_read, avs_write} <= 4'h0;
		{want_single, want_fs, ee_byte_index, ee_byte_data} <= 13'h0;
		{avs_address, avs_writedata, avs_byteenable} <= {5'h0, 32'h0, 4'hF};
		t_dflt_self;
		t_dflt_bus;
		t_ee;
		t_mgmt;
		end_sim;
	end
	// watchdog well beyond the fewer than one hundred cycles needed
	initial begin
		repeat (3000) @(posedge clk);
		num_errors = num_errors + 1;
		end_sim;
	end
endmodule // hub_config_option_select_bench
